// ==== hw/nvc_pkg.sv ====
// Purpose: shared constants and types for the host-side nvsram controller
// Assumes: 200 MHz clk, device reached only through its parallel pins
// Notes:   durations are in device time units, cycle counts derived below
//
// Functional notes
// R1 - device reads when select and drive low
// R2 - read outputs track address until controls change
// R3 - host holds address until write strobe rises
// R4 - device drops outputs if drive low writing
// R5 - pin store when trigger, select, write low
// R6 - store end under read conditions drives outputs
// R7 - pin store starts only on trigger fall
// R8 - low supply blocks or abandons stores
// R9 - low supply never aborts a recall
// R10 - pin recall when last control falls, write high
// R11 - recall repeats only on fresh trigger fall
// R12 - recall clears SRAM then copies shadow; the model copies shadow without a clear
// R13 - host waits recall time after power-up
// R14 - pin variant ignores software read sequence; the model also starts store and recall from the sequence
// R15 - six reads ending 0F0F start store
// R16 - five reads then 0F0E start recall
// R17 - host uses read cycles only for sequence
// R18 - wrong intervening address aborts software sequence
// R19 - new sequence only after completion or abort
// R20 - software operation ignores inputs until done
// R21 - host limits address skew, uses select-clocked reads
// R22 - host holds address steady during recall
// R23 - host waits full store or recall count
package nvc_pkg;

   // ==========================================================
   // clock and timing
   localparam int CLK_PERIOD_PS   = 5000;             // 200 MHz
   localparam int STORE_MS        = 10;               // store_duration, longest
   localparam int RECALL_US       = 20;               // recall duration, longest
   localparam int ACCESS_NS       = 45;               // slowest access grade
   localparam int WR_PULSE_NS     = 45;               // write strobe width
   localparam int TRIG_PULSE_NS   = 45;               // trigger low width
   // waits must cover the longest duration, so round up
   // whole cycles per ms first, so the product stays inside 32 bits
   localparam int STORE_CYC  = STORE_MS * (1000000000 / CLK_PERIOD_PS);
   localparam int RECALL_CYC = (RECALL_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WR_CYC     = (WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TRIG_CYC   = (TRIG_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W      = 22;                    // holds STORE_CYC

   // ==========================================================
   // geometry
   localparam int ADDR_W = 13;                        // 8192 bytes
   localparam int DATA_W = 8;

   // ==========================================================
   // software sequence addresses
   localparam logic [ADDR_W-1:0] SEQ_A0     = 13'h0000;
   localparam logic [ADDR_W-1:0] SEQ_A1     = 13'h1555;
   localparam logic [ADDR_W-1:0] SEQ_A2     = 13'h0AAA;
   localparam logic [ADDR_W-1:0] SEQ_A3     = 13'h1FFF;
   localparam logic [ADDR_W-1:0] SEQ_A4     = 13'h10F0;
   localparam logic [ADDR_W-1:0] SEQ_STORE  = 13'h0F0F;
   localparam logic [ADDR_W-1:0] SEQ_RECALL = 13'h0F0E;
   localparam logic [2:0]        SEQ_LAST   = 3'h5;   // index of sixth read

   // ==========================================================
   // command codes
   typedef enum logic [2:0] {
      NVC_CMD_READ, NVC_CMD_WRITE, NVC_CMD_PIN_STORE, NVC_CMD_PIN_RECALL,
      NVC_CMD_SW_STORE, NVC_CMD_SW_RECALL, NVC_CMD_WAIT_PWRUP
   } nvc_cmd_t;

   typedef enum logic [2:0] {
      NVC_IDLE, NVC_ACC, NVC_STROBE, NVC_SEQ, NVC_BUSY, NVC_GAP
   } nvc_st_t;

   // user request
   typedef struct packed {
      nvc_cmd_t            cmd;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } nvc_req_t;

   // pins toward the device
   typedef struct packed {
      logic                sel_n;
      logic                drive_n;
      logic                wr_n;
      logic                nonvol_trigger_n;
      logic [ADDR_W-1:0]   addr_lines;
      logic [DATA_W-1:0]   data_out;
      logic                data_oe;
   } nvc_pins_t;

endpackage

// ==== hw/nvc_ctrl.sv ====
// Purpose: host controller driving a nonvolatile SRAM through its pins
// Assumes: req_valid held until req_ready; device async, data synchronised
// Notes:   one request at a time, long waits counted in clk cycles
`timescale 1ns/1ps
module nvc_ctrl (
   // clock, reset, enable
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clk_en,
   // user request
   input  wire logic                  req_valid,
   input  wire nvc_pkg::nvc_req_t     req,
   output logic                       req_ready,
   output logic                       rsp_valid,
   output logic [nvc_pkg::DATA_W-1:0] rsp_data,
   // device pins
   output nvc_pkg::nvc_pins_t         pins,
   input  wire logic [nvc_pkg::DATA_W-1:0] data_in
);
   import nvc_pkg::*;

   // ==========================================================
   // state record
   typedef struct packed {
      nvc_st_t             st;
      nvc_cmd_t            cmd;
      logic [CNT_W-1:0]    cnt;       // cycle counter
      logic [2:0]          step;      // software sequence index
      logic                pwr_done;  // power-up recall time elapsed
      logic [DATA_W-1:0]   sync1;     // first stage, feeds sync2 only
      logic [DATA_W-1:0]   sync2;
      nvc_pins_t           pins;
      logic                ready;
      logic                rvalid;
      logic [DATA_W-1:0]   rdata;
   } nvc_state_t;

   nvc_state_t cur;                   // registered state
   nvc_state_t next_cur;              // next value

   // address of a sequence step
   function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] i, input nvc_cmd_t c);
      case (i)
         3'h0:    seq_addr = SEQ_A0;
         3'h1:    seq_addr = SEQ_A1;
         3'h2:    seq_addr = SEQ_A2;
         3'h3:    seq_addr = SEQ_A3;
         3'h4:    seq_addr = SEQ_A4;
         default: seq_addr = (c == NVC_CMD_SW_STORE) ? SEQ_STORE : SEQ_RECALL; // R15 R16
      endcase
   endfunction

   // cycle count to compare against
   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n);
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      next_cur        = cur;
      next_cur.rvalid = 1'b0;
      next_cur.sync1  = data_in;
      next_cur.sync2  = cur.sync1;
      case (cur.st)
         // wait for power-up recall, then accept
         NVC_IDLE: begin
            next_cur.pins.sel_n            = 1'b1;
            next_cur.pins.drive_n          = 1'b1;
            next_cur.pins.wr_n             = 1'b1;
            next_cur.pins.nonvol_trigger_n = 1'b1;
            next_cur.pins.data_oe          = 1'b0;
            if (!cur.pwr_done) begin
               // no access until recall time after power-up
               if (cur.cnt == cyc(RECALL_CYC)) begin // R13
                  next_cur.pwr_done = 1'b1;
                  next_cur.ready    = 1'b1;
                  next_cur.cnt      = '0;
               end else begin
                  next_cur.cnt = cur.cnt + 1'b1;
               end
            end else if (cur.ready && req_valid) begin
               next_cur.ready           = 1'b0;
               next_cur.cmd             = req.cmd;
               next_cur.cnt             = '0;
               next_cur.step            = '0;
               next_cur.pins.addr_lines = req.addr;
               next_cur.pins.data_out   = req.wdata;
               if (req.cmd == NVC_CMD_READ) begin
                  next_cur.pins.sel_n   = 1'b0;
                  next_cur.pins.drive_n = 1'b0;
                  next_cur.st           = NVC_ACC;
               end else if (req.cmd == NVC_CMD_WRITE) begin
                  // drive stays high so the bus never contends
                  next_cur.pins.sel_n   = 1'b0;  // R3 R4
                  next_cur.pins.data_oe = 1'b1;
                  next_cur.st           = NVC_STROBE;
               end else if (req.cmd == NVC_CMD_PIN_STORE) begin
                  // select first; write and trigger fall together in strobe,
                  // so no plain sram write cycle is ever presented
                  next_cur.pins.sel_n = 1'b0;    // R5
                  next_cur.st         = NVC_STROBE;
               end else if (req.cmd == NVC_CMD_PIN_RECALL) begin
                  // select and drive low first, trigger falls last
                  next_cur.pins.sel_n   = 1'b0;  // R10
                  next_cur.pins.drive_n = 1'b0;
                  next_cur.st           = NVC_STROBE;
               end else if (req.cmd == NVC_CMD_WAIT_PWRUP) begin
                  next_cur.pwr_done = 1'b0;
                  next_cur.st       = NVC_IDLE;
               end else begin
                  // software sequence: address first, select per read
                  next_cur.pins.addr_lines = SEQ_A0;
                  next_cur.st              = NVC_SEQ;
               end
            end
         end
         // read access in progress
         NVC_ACC: begin
            if (cur.cnt == cyc(ACCESS_CYC + 2)) begin
               next_cur.rdata        = cur.sync2;
               next_cur.rvalid       = 1'b1;
               next_cur.pins.sel_n   = 1'b1;
               next_cur.pins.drive_n = 1'b1;
               next_cur.st           = NVC_GAP;
               next_cur.cnt          = '0;
            end else begin
               next_cur.cnt = cur.cnt + 1'b1;
            end
         end
         // timed strobe for write or pin trigger
         NVC_STROBE: begin
            next_cur.cnt = cur.cnt + 1'b1;
            if (cur.cmd == NVC_CMD_WRITE) begin
               next_cur.pins.wr_n = 1'b0;
               if (cur.cnt == cyc(WR_CYC)) begin
                  // strobe rises before address may move
                  next_cur.pins.wr_n = 1'b1;     // R3
                  next_cur.st        = NVC_GAP;
                  next_cur.cnt       = '0;
               end
            end else begin
               // fresh high-to-low trigger edge every time
               next_cur.pins.nonvol_trigger_n = 1'b0; // R7 R11
               if (cur.cmd == NVC_CMD_PIN_STORE) begin
                  next_cur.pins.wr_n = 1'b0;     // R5
               end
               if (cur.cnt == cyc(TRIG_CYC)) begin
                  next_cur.pins.nonvol_trigger_n = 1'b1;
                  next_cur.pins.wr_n             = 1'b1;
                  next_cur.st                    = NVC_BUSY;
                  next_cur.cnt                   = '0;
               end
            end
         end
         // six select-clocked reads, removes skew concern
         NVC_SEQ: begin
            next_cur.cnt        = cur.cnt + 1'b1;
            next_cur.pins.sel_n = 1'b0;          // R17 R21
            if (cur.cnt == cyc(ACCESS_CYC)) begin
               next_cur.pins.sel_n = 1'b1;
            end else if (cur.cnt == cyc(ACCESS_CYC + 1)) begin
               next_cur.pins.sel_n = 1'b1;
               next_cur.cnt        = '0;
               if (cur.step == SEQ_LAST) begin
                  next_cur.st = NVC_BUSY;
               end else begin
                  next_cur.step            = cur.step + 1'b1;
                  next_cur.pins.addr_lines = seq_addr(cur.step + 1'b1, cur.cmd); // R18 R19
               end
            end
         end
         // device busy: address held, lines released
         NVC_BUSY: begin
            next_cur.pins.sel_n   = 1'b1;
            next_cur.pins.drive_n = 1'b1;
            next_cur.cnt          = cur.cnt + 1'b1;
            if ((cur.cmd == NVC_CMD_PIN_STORE || cur.cmd == NVC_CMD_SW_STORE)
                ? (cur.cnt == cyc(STORE_CYC)) : (cur.cnt == cyc(RECALL_CYC))) begin
               next_cur.st  = NVC_GAP;               // R22 R23
               next_cur.cnt = '0;
            end
         end
         // one recovery cycle, then ready
         default: begin
            next_cur.pins.data_oe = 1'b0;
            next_cur.ready        = 1'b1;
            next_cur.st           = NVC_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cur                       <= '0;
         cur.st                    <= NVC_IDLE;
         cur.pins.sel_n            <= 1'b1;
         cur.pins.drive_n          <= 1'b1;
         cur.pins.wr_n             <= 1'b1;
         cur.pins.nonvol_trigger_n <= 1'b1;
      end else if (clk_en) begin
         cur <= next_cur;
      end
   end

   assign req_ready = cur.ready;
   assign rsp_valid = cur.rvalid;
   assign rsp_data  = cur.rdata;
   assign pins      = cur.pins;

endmodule

// ==== verif/nvc_ctrl_checker.sv ====
// Purpose: port-level checks on the nvsram host controller
// Assumes: clk_en held high while the wait counters matter
// Notes:   counters stand in for waits too long to unroll
`timescale 1ns/1ps
module nvc_ctrl_checker (
   // clock and reset
   input wire logic                       clk,
   input wire logic                       sys_rst,
   input wire logic                       clk_en,
   // user side
   input wire logic                       req_valid,
   input wire nvc_pkg::nvc_req_t          req,
   input wire logic                       req_ready,
   input wire logic                       rsp_valid,
   input wire logic [nvc_pkg::DATA_W-1:0] rsp_data,
   // device pins
   input wire nvc_pkg::nvc_pins_t         pins,
   input wire logic [nvc_pkg::DATA_W-1:0] data_in
);
   import nvc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // wait counters, two cycles of margin for handshake slack
   logic [CNT_W-1:0] pw_left;  // power-up recall left
   logic [CNT_W-1:0] rc_left;  // pin recall left
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pw_left <= CNT_W'(RECALL_CYC - 2);
         rc_left <= '0;
      end else begin
         pw_left <= (pw_left != 0) ? pw_left - 1'b1 : pw_left;
         if ($fell(pins.nonvol_trigger_n) && pins.wr_n) begin
            rc_left <= CNT_W'(RECALL_CYC - 2);
         end else if (rc_left != 0) begin
            rc_left <= rc_left - 1'b1;
         end
      end
   end
   // ==========================================================
   // properties
   a_write_drive: assert property (
      !pins.wr_n && pins.nonvol_trigger_n |-> pins.data_oe && pins.drive_n && !pins.sel_n)
      else $error("write strobe without data or with output drive");
   a_write_addr: assert property (
      !pins.wr_n && pins.nonvol_trigger_n |=> $stable(pins.addr_lines))
      else $error("address moved under write strobe");
   a_store_start: assert property (
      $fell(pins.nonvol_trigger_n) && !pins.wr_n |-> !pins.sel_n && pins.drive_n)
      else $error("store trigger with wrong controls");
   a_recall_start: assert property (
      $fell(pins.nonvol_trigger_n) && pins.wr_n |-> !pins.sel_n && !pins.drive_n)
      else $error("recall trigger with wrong controls");
   a_trig_width: assert property (
      $fell(pins.nonvol_trigger_n) |-> !pins.nonvol_trigger_n [*8])
      else $error("trigger pulse too short");
   a_recall_hold: assert property (
      rc_left != 0 |-> $stable(pins.addr_lines) && !req_ready)
      else $error("address moved or ready during recall");
   a_pwrup_wait: assert property (pw_left != 0 |-> !req_ready)
      else $error("ready before power-up recall ended");
   a_read_strobe: assert property (
      rsp_valid |-> $past(!pins.sel_n && !pins.drive_n && pins.wr_n))
      else $error("read answer without read strobes");
endmodule
bind nvc_ctrl nvc_ctrl_checker u_nvc_ctrl_checker (.clk(clk), .sys_rst(sys_rst),
   .clk_en(clk_en), .req_valid(req_valid), .req(req), .req_ready(req_ready),
   .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .data_in(data_in));

// ==== verif/nvc_dev_model.sv ====
// Purpose: behavioural nonvolatile sram seen from its pins
// Assumes: pins change only after clk rises
// Notes:   store and recall shortened to OP_CYC, host waits longer
`timescale 1ns/1ps
module nvc_dev_model #(parameter int OP_CYC = 64) (
   // clock and pins
   input wire logic                       clk,
   input wire nvc_pkg::nvc_pins_t         pins,
   output logic [nvc_pkg::DATA_W-1:0]     data_in
);
   import nvc_pkg::*;
   localparam logic [ADDR_W-1:0] LEAD [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
   logic [DATA_W-1:0] sram [8192];  // volatile array
   logic [DATA_W-1:0] shadow [8192];  // nonvolatile copy
   logic [DATA_W-1:0] last;  // last wire level
   nvc_pins_t         prev;  // pins one edge ago
   logic [2:0]        idx;  // sequence step
   int                busy;  // cycles left in operation
   logic              storing, go_st, go_rc, rd;
   // read drive, floating wire toggles so no stale value passes
   assign rd = !pins.sel_n && !pins.drive_n && pins.wr_n && pins.nonvol_trigger_n && busy == 0;
   assign data_in = pins.data_oe ? pins.data_out : rd ? sram[pins.addr_lines] : ~last;
   initial begin
      for (int i = 0; i < 8192; i++) begin
         shadow[i] = 8'(i) ^ 8'h5A;
         sram[i] = shadow[i];  // power-up recall
      end
      prev = '1;
      idx = 3'h0;
      busy = 0;
      storing = 1'b0;
   end
   always @(posedge clk) begin
      go_st = 1'b0;
      go_rc = 1'b0;
      prev <= pins;
      last <= data_in;
      if (busy != 0) begin  // inputs ignored
         busy <= busy - 1;
         if (busy == 1 && storing) begin
            for (int i = 0; i < 8192; i++) shadow[i] = sram[i];
         end
      end else if (prev.nonvol_trigger_n && !pins.nonvol_trigger_n && !pins.sel_n) begin
         go_st = !pins.wr_n && pins.drive_n;
         go_rc = pins.wr_n && !pins.drive_n;
      end else if (!prev.wr_n && pins.wr_n && !pins.sel_n && pins.nonvol_trigger_n) begin
         sram[pins.addr_lines] <= data_in;
      end else if (!prev.sel_n && pins.sel_n && pins.wr_n) begin
         go_st = idx == SEQ_LAST && prev.addr_lines == SEQ_STORE;
         go_rc = idx == SEQ_LAST && prev.addr_lines == SEQ_RECALL;
         if (idx < SEQ_LAST && prev.addr_lines == LEAD[idx]) idx <= idx + 3'h1;
         else idx <= (prev.addr_lines == SEQ_A0) ? 3'h1 : 3'h0;
      end
      if (go_st || go_rc) begin
         busy <= OP_CYC;
         storing <= go_st;
      end
      if (go_rc) begin  // copy shadow straight into sram, no clear, shadow untouched
         for (int i = 0; i < 8192; i++) sram[i] <= shadow[i];
      end
   end
endmodule

// ==== verif/nvsram_store_recall_control_tb_top.sv ====
// Purpose: self-checking bench for the nvsram host controller
// Assumes: inputs change at falling clk edges
// Notes:   store waits never finish here, a reset cuts them short
`timescale 1ns/1ps
module nvsram_store_recall_control_tb_top;
   import nvc_pkg::*;
   typedef struct packed {
      nvc_cmd_t cmd; logic [12:0] a; logic [7:0] d; logic [7:0] e;
   } nvc_row_t;
   logic        clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, req_valid = 1'b0;
   nvc_req_t    req = '0;
   logic        req_ready, rsp_valid;
   logic [7:0]  rsp_data, data_in;
   nvc_pins_t   pins;
   int          err_total = 0, compares = 0, cyc = 0;
   logic [7:0]  pat [2] = '{8'hC3, 8'h77};  // stored bytes
   nvc_row_t    rows [12] = '{
      '{NVC_CMD_WRITE, 13'h0000, 8'hA5, 8'h00}, '{NVC_CMD_WRITE, 13'h1FFF, 8'h3C, 8'h00},
      '{NVC_CMD_READ, 13'h0000, 8'h00, 8'hA5}, '{NVC_CMD_READ, 13'h1FFF, 8'h00, 8'h3C},
      '{NVC_CMD_WRITE, 13'h0AAA, 8'h11, 8'h00}, '{NVC_CMD_SW_RECALL, 13'h0, 8'h0, 8'h0},
      '{NVC_CMD_READ, 13'h0AAA, 8'h00, 8'hF0}, '{NVC_CMD_READ, 13'h0000, 8'h00, 8'h5A},
      '{NVC_CMD_WRITE, 13'h1FFF, 8'h99, 8'h00}, '{NVC_CMD_PIN_RECALL, 13'h0, 8'h0, 8'h0},
      '{NVC_CMD_READ, 13'h1FFF, 8'h00, 8'hA5}, '{NVC_CMD_WAIT_PWRUP, 13'h0, 8'h0, 8'h0}};
   always #2.5 clk = ~clk;
   nvc_ctrl u_nvc_ctrl (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .pins(pins), .data_in(data_in));
   nvc_dev_model u_nvc_dev_model (.clk(clk), .pins(pins), .data_in(data_in));
   // ==========================================================
   // compare and closing tasks
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (err_total == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========================================================
   // request driver, bounded waits on ready and answer
   task automatic wait_ready;
      for (int i = 0; i < 5000 && req_ready !== 1'b1; i++) @(negedge clk);
   endtask
   task automatic do_req(input nvc_row_t r);
      wait_ready();
      req_valid = 1'b1;
      req = '{r.cmd, r.a, r.d};
      @(negedge clk);
      req_valid = 1'b0;
      if (r.cmd == NVC_CMD_READ) begin
         for (int i = 0; i < 40 && rsp_valid !== 1'b1; i++) @(negedge clk);
         chk_bit(rsp_valid, 1'b1);
         chk_byte(rsp_data, r.e);
      end
   endtask
   task automatic do_reset;
      sys_rst = 1'b1;
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3990) @(negedge clk);
      chk_bit(req_ready, 1'b0);
      wait_ready();
      chk_bit(req_ready, 1'b1);
   endtask
   // hang guard, about twice the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         report_and_stop();
      end
   end
   // ==========================================================
   // main sequence: table, then pin and software store waits cut short by reset
   initial begin
      do_reset();
      foreach (rows[i]) do_req(rows[i]);
      for (int k = 0; k < 2; k++) begin
         do_req('{NVC_CMD_WRITE, 13'h0000, pat[k], 8'h00});
         do_req('{k ? NVC_CMD_SW_STORE : NVC_CMD_PIN_STORE, 13'h0, 8'h0, 8'h0});
         repeat (200) @(negedge clk);
         chk_bit(req_ready, 1'b0);
         do_reset();
         do_req('{k ? NVC_CMD_SW_RECALL : NVC_CMD_PIN_RECALL, 13'h0, 8'h0, 8'h0});
         do_req('{NVC_CMD_READ, 13'h0000, 8'h00, pat[k]});
      end
      report_and_stop();
   end
endmodule
